// ### hw/bus_area_map.vh
// constants for the external bus area configuration block
`ifndef BUS_AREA_MAP_VH
`define BUS_AREA_MAP_VH

// ======================================================
// register byte addresses
`define AREA_FUNCTION_CONTROL_ADDR 12'h000
`define READ_WAIT_CONTROL_ADDR     12'h004
`define LONG_WAIT_CONTROL_ADDR     12'h008

// ======================================================
// reset values
`define AREA_FUNCTION_CONTROL_RST  16'h0000
`define READ_WAIT_CONTROL_RST      16'hffff
`define LONG_WAIT_CONTROL_RST      2'h3

// ======================================================
// writable masks and reserved patterns
`define AREA_FUNCTION_WMASK        16'hf800
`define READ_WAIT_WMASK            16'hff02
`define READ_WAIT_ONES             16'h00fd

// ======================================================
// field positions
`define AFC_DRAM_SELECT_BIT        15
`define AFC_MUXED_SELECT_BIT       14
`define AFC_OVERLAP_BIT            13
`define AFC_READ_DUTY_BIT          12
`define AFC_BYTE_STROBE_BIT        11
`define RWC_AREA_LSB               8
`define RWC_WRITE_PITCH_BIT        1

// ======================================================
// state counts
`define STATES_FIXED_ONE           3'h1
`define STATES_WAITED_TWO          3'h2
`define STATES_MUXED_IO            3'h4
`define STATES_PERIPHERAL          3'h3

// ======================================================
// area kinds
`define KIND_EXT                   3'h0
`define KIND_DRAM                  3'h1
`define KIND_MUXED                 3'h2
`define KIND_PERIPH                3'h3
`define KIND_ONCHIP                3'h4
`define KIND_REFRESH               3'h5

`endif

// ### hw/read_cycle_timer.v
// per-access state counter that stretches a bus cycle by wait input
`timescale 1ns/1ps
`include "bus_area_map.vh"

module read_cycle_timer (
   // clock and reset
   input  wire       clock_i,
   input  wire       rstn_i,
   input  wire       enable_i,
   // cycle request
   input  wire       start_i,
   input  wire [2:0] base_states_i,
   input  wire       sample_wait_i,
   input  wire       wait_n_i,
   // status
   output reg        busy_o,
   output reg        done_o,
   output reg  [7:0] states_o
);

   // ======================================================
   // state machine
   localparam [1:0] IDLE = 2'b01;
   localparam [1:0] RUN  = 2'b10;

   reg [1:0] state;
   reg [2:0] remain;
   reg       sample;
   reg [7:0] count;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state    <= IDLE;
         remain   <= 3'h0;
         sample   <= 1'b0;
         count    <= 8'h00;
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         states_o <= 8'h00;
      end else if (enable_i) begin
         done_o <= 1'b0;
         case (state)
            IDLE: begin
               if (start_i) begin
                  state  <= RUN;
                  remain <= base_states_i - 3'h1;
                  sample <= sample_wait_i;
                  count  <= 8'h01;
                  busy_o <= 1'b1;
               end
            end
            RUN: begin
               // wait is looked at in the last fixed state and again in each wait state after it
               if (remain != 3'h0) begin
                  remain <= remain - 3'h1;
                  count  <= count + 8'h01;
               end else if (sample && !wait_n_i && count != 8'hff) begin
                  count <= count + 8'h01;
               end else begin
                  state    <= IDLE;
                  busy_o   <= 1'b0;
                  done_o   <= 1'b1;
                  states_o <= count;
               end
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

endmodule // read_cycle_timer

// ### hw/external_bus_area_wait_config.v
// area function and read wait configuration with ahb-lite access
// What this block does
// - area function register, 16 bits, zero on power-on reset only
// - bit 15 makes area 1 dram; dram settings valid only then
// - bit 14 makes area 6 multiplexed address/data space
// - bit 13 clear keeps internal and external accesses apart; set overlaps
// - bit 12 picks read strobe high duty: 50 or 35 percent
// - bit 11 picks byte strobes: upper/lower store or low/high select
// - area function bits 10..0 read zero; software writes zero
// - read wait register, 16 bits, all ones on power-on reset only
// - read wait bits 15..8 enable wait sampling for areas 7..0
// - areas 1,3,4,5,7 external: one state, or two plus waits; area 1 writes always two plus waits
// - areas 0,2 external: one plus long wait; area 6 external: two; plus waits if set
// - dram read column cycle: one state, or two plus waits
// - refresh with area 1 bit set inserts refresh waits, ignores wait
// - multiplexed area 6 reads take four states plus waits
// - peripheral area 5 reads take three states, no sampling
// - on-chip rom and ram reads take one state, no sampling
// - read wait bits 7..2 and 0 read one; software writes one
// - dram write pitch bit: one state, or two plus waits
// - areas 0 and 2 long wait is one to four states
`timescale 1ns/1ps
`include "bus_area_map.vh"

module external_bus_area_wait_config (
   // clock, reset, enable
   input  wire        clock_i,
   input  wire        rstn_i,
   input  wire        clken_i,
   // ahb-lite slave
   input  wire        hsel_i,
   input  wire [11:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // bus cycle request
   input  wire        access_start_i,
   input  wire [2:0]  access_area_i,
   input  wire        access_write_i,
   input  wire        access_onchip_i,
   input  wire        refresh_start_i,
   input  wire [1:0]  refresh_wait_i,
   input  wire        wait_n_i,
   // area configuration outputs
   output reg         area1_dram_o,
   output reg         area6_muxed_o,
   output reg         overlap_mode_o,
   output reg         read_strobe_duty_o,
   output reg         byte_strobe_select_o,
   output reg  [7:0]  wait_sample_enable_o,
   output reg         dram_write_pitch_o,
   // cycle status
   output wire        cycle_busy_o,
   output wire        cycle_done_o,
   output wire [7:0]  cycle_states_o
);

   // ======================================================
   // registers
   reg [15:0] area_function_control;
   reg [15:0] read_wait_control;
   reg [1:0]  long_wait_control;
   reg        wr_pending;
   reg [11:0] wr_addr;
   reg [15:0] wr_lanes;
   reg [31:0] rdata;

   wire area1_dram_select  = area_function_control[`AFC_DRAM_SELECT_BIT];
   wire area6_muxed_select = area_function_control[`AFC_MUXED_SELECT_BIT];
   wire [7:0] area_read_wait_bits = read_wait_control[15:`RWC_AREA_LSB];
   wire dram_write_pitch   = read_wait_control[`RWC_WRITE_PITCH_BIT];

   // ======================================================
   // ahb-lite slave, zero wait while clken_i is high, always okay
   wire take = hsel_i && hready_i && htrans_i[1];

   // stall the bus while frozen, so no transfer is taken and then lost
   assign hreadyout_o = clken_i;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata;

   function [31:0] read_mux;
      input [11:0] addr;
      input [15:0] afc;
      input [15:0] rwc;
      input [1:0]  lwc;
      begin
         case (addr)
            `AREA_FUNCTION_CONTROL_ADDR: read_mux = {16'h0000, afc & `AREA_FUNCTION_WMASK};
            `READ_WAIT_CONTROL_ADDR:     read_mux = {16'h0000, rwc | `READ_WAIT_ONES};
            `LONG_WAIT_CONTROL_ADDR:     read_mux = {30'h0, lwc};
            default:                     read_mux = 32'h00000000;
         endcase
      end
   endfunction

   // byte lanes of the low halfword touched by one transfer
   function [15:0] lane_mask;
      input [2:0] size;
      input [1:0] low;
      begin
         case (size)
            3'h0: begin
               lane_mask = (low == 2'h0) ? 16'h00ff :
                           (low == 2'h1) ? 16'hff00 : 16'h0000;
            end
            3'h1: begin
               lane_mask = low[1] ? 16'h0000 : 16'hffff;
            end
            default: begin
               lane_mask = 16'hffff;
            end
         endcase
      end
   endfunction

   function [15:0] merge_lanes;
      input [15:0] old;
      input [15:0] fresh;
      input [15:0] lanes;
      begin
         merge_lanes = (old & ~lanes) | (fresh & lanes);
      end
   endfunction

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         area_function_control <= `AREA_FUNCTION_CONTROL_RST;
         read_wait_control     <= `READ_WAIT_CONTROL_RST;
         long_wait_control     <= `LONG_WAIT_CONTROL_RST;
         wr_pending            <= 1'b0;
         wr_addr               <= 12'h000;
         wr_lanes              <= 16'h0000;
         rdata                 <= 32'h00000000;
      end else if (clken_i) begin
         wr_pending <= take && hwrite_i;
         if (take) begin
            wr_addr  <= {haddr_i[11:2], 2'b00};
            wr_lanes <= lane_mask(hsize_i, haddr_i[1:0]);
         end
         if (take && !hwrite_i) begin
            rdata <= read_mux({haddr_i[11:2], 2'b00}, area_function_control,
                              read_wait_control, long_wait_control);
         end
         // write lands in the data phase; narrow writes touch only their own lanes
         if (wr_pending) begin
            case (wr_addr)
               `AREA_FUNCTION_CONTROL_ADDR: begin
                  area_function_control <= merge_lanes(area_function_control,
                                                       hwdata_i[15:0], wr_lanes) &
                                           `AREA_FUNCTION_WMASK;
               end
               `READ_WAIT_CONTROL_ADDR: begin
                  // reserved bits held high whatever is written
                  read_wait_control <= merge_lanes(read_wait_control, hwdata_i[15:0],
                                                   wr_lanes) | `READ_WAIT_ONES;
               end
               `LONG_WAIT_CONTROL_ADDR: begin
                  if (wr_lanes[0]) begin
                     long_wait_control <= hwdata_i[1:0];
                  end
               end
               default: begin
                  long_wait_control <= long_wait_control;
               end
            endcase
         end
      end
   end

   // ======================================================
   // configuration outputs
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         area1_dram_o         <= 1'b0;
         area6_muxed_o        <= 1'b0;
         overlap_mode_o       <= 1'b0;
         read_strobe_duty_o   <= 1'b0;
         byte_strobe_select_o <= 1'b0;
         wait_sample_enable_o <= 8'hff;
         dram_write_pitch_o   <= 1'b1;
      end else if (clken_i) begin
         area1_dram_o         <= area1_dram_select;
         area6_muxed_o        <= area6_muxed_select;
         overlap_mode_o       <= area_function_control[`AFC_OVERLAP_BIT];
         read_strobe_duty_o   <= area_function_control[`AFC_READ_DUTY_BIT];
         byte_strobe_select_o <= area_function_control[`AFC_BYTE_STROBE_BIT];
         wait_sample_enable_o <= area_read_wait_bits;
         // pitch only meaningful for dram; external area 1 writes stay long
         dram_write_pitch_o   <= dram_write_pitch | ~area1_dram_select;
      end
   end

   // ======================================================
   // state count selection
   function [2:0] area_kind;
      input [2:0] area;
      input       onchip;
      input       dram;
      input       muxed;
      begin
         if (area == 3'h5 && onchip) begin
            area_kind = `KIND_PERIPH;
         end else if ((area == 3'h0 || area == 3'h7) && onchip) begin
            area_kind = `KIND_ONCHIP;
         end else if (area == 3'h1 && dram) begin
            area_kind = `KIND_DRAM;
         end else if (area == 3'h6 && muxed) begin
            area_kind = `KIND_MUXED;
         end else begin
            area_kind = `KIND_EXT;
         end
      end
   endfunction

   reg [2:0] base_states;
   reg       sample_wait;
   reg [2:0] kind;
   reg       rw_bit;
   reg       long_area;

   always @* begin
      kind        = area_kind(access_area_i, access_onchip_i, area1_dram_select,
                              area6_muxed_select);
      rw_bit      = area_read_wait_bits[access_area_i];
      long_area   = (access_area_i == 3'h0) || (access_area_i == 3'h2) ||
                    (access_area_i == 3'h6);
      base_states = `STATES_FIXED_ONE;
      sample_wait = 1'b0;
      if (refresh_start_i) begin
         // refresh: fixed wait from refresh setting when area 1 wait bit set, wait input ignored
         base_states = area_read_wait_bits[1] ?
                       (`STATES_FIXED_ONE + {1'b0, refresh_wait_i}) :
                       `STATES_FIXED_ONE;
         sample_wait = 1'b0;
      end else begin
         case (kind)
            `KIND_PERIPH: begin
               base_states = `STATES_PERIPHERAL;
            end
            `KIND_ONCHIP: begin
               base_states = `STATES_FIXED_ONE;
            end
            `KIND_MUXED: begin
               base_states = `STATES_MUXED_IO;
               sample_wait = 1'b1;
            end
            `KIND_DRAM: begin
               if (access_write_i) begin
                  base_states = dram_write_pitch ? `STATES_WAITED_TWO : `STATES_FIXED_ONE;
                  sample_wait = dram_write_pitch;
               end else begin
                  base_states = rw_bit ? `STATES_WAITED_TWO : `STATES_FIXED_ONE;
                  sample_wait = rw_bit;
               end
            end
            default: begin
               if (access_write_i && access_area_i == 3'h1) begin
                  base_states = `STATES_WAITED_TWO;
                  sample_wait = 1'b1;
               end else if (long_area && access_area_i != 3'h6) begin
                  // one state plus one to four long waits
                  base_states = `STATES_FIXED_ONE + `STATES_FIXED_ONE +
                                {1'b0, long_wait_control};
                  sample_wait = rw_bit;
               end else if (long_area) begin
                  base_states = `STATES_WAITED_TWO;
                  sample_wait = rw_bit;
               end else begin
                  base_states = rw_bit ? `STATES_WAITED_TWO : `STATES_FIXED_ONE;
                  sample_wait = rw_bit;
               end
            end
         endcase
      end
   end

   // ======================================================
   // cycle timer
   read_cycle_timer u_timer (
      .clock_i       (clock_i),
      .rstn_i        (rstn_i),
      .enable_i      (clken_i),
      .start_i       (access_start_i | refresh_start_i),
      .base_states_i (base_states),
      .sample_wait_i (sample_wait),
      .wait_n_i      (wait_n_i),
      .busy_o        (cycle_busy_o),
      .done_o        (cycle_done_o),
      .states_o      (cycle_states_o)
   );

endmodule // external_bus_area_wait_config

// ### tb/wait_responder.sv
// far-side device that stalls a bus cycle through the wait line
`timescale 1ns/1ps
module wait_responder (
   // clock and reset
   input  wire       clock_i,
   input  wire       rstn_i,
   // cycle start and stall length
   input  wire       start_i,
   input  wire [3:0] stall_i,
   // wait line, pulled up when idle
   output wire       wait_n_o
);
   reg [3:0] left;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i)
         left <= 4'h0;
      else if (start_i)
         left <= stall_i;
      else if (left != 4'h0)
         left <= left - 4'h1;
   end
   // pull-up wins once the stall has run out
   assign wait_n_o = (left == 4'h0);
endmodule // wait_responder

// ### tb/bus_area_monitor.sv
// port checker for the area configuration block
`timescale 1ns/1ps
module bus_area_monitor (
   // clock and reset
   input wire        clock_i,
   input wire        rstn_i,
   // register bus
   input wire        hsel_i,
   input wire [11:0] haddr_i,
   input wire [1:0]  htrans_i,
   input wire        hwrite_i,
   input wire [31:0] hwdata_i,
   input wire        hready_i,
   input wire [31:0] hrdata_o,
   input wire        hresp_o,
   // cycle timing
   input wire        access_start_i,
   input wire [2:0]  access_area_i,
   input wire        access_onchip_i,
   input wire        cycle_done_o,
   input wire        cycle_busy_o,
   input wire [7:0]  cycle_states_o,
   // configuration outputs
   input wire        area1_dram_o,
   input wire        area6_muxed_o,
   input wire        overlap_mode_o,
   input wire        read_strobe_duty_o,
   input wire        byte_strobe_select_o,
   input wire [7:0]  wait_sample_enable_o,
   input wire        dram_write_pitch_o
);
   // ======================================
   // data phase tracking
   reg        ph_wr;
   reg        ph_rd;
   reg [11:0] ph_addr;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_wr   <= 1'b0;
         ph_rd   <= 1'b0;
         ph_addr <= 12'h000;
      end else begin
         ph_wr   <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
         ph_rd   <= hsel_i && hready_i && htrans_i[1] && !hwrite_i;
         ph_addr <= haddr_i;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ======================================
   // sequences
   sequence afc_wr; ph_wr && ph_addr == 12'h000; endsequence
   sequence rwc_wr; ph_wr && ph_addr == 12'h004; endsequence
   sequence periph_go; access_start_i && access_onchip_i && access_area_i == 3'h5; endsequence
   sequence rom_go; access_start_i && access_onchip_i &&
      (access_area_i == 3'h0 || access_area_i == 3'h7); endsequence
   // ======================================
   // assertions
   a_dram_follows: assert property (afc_wr |-> ##2 area1_dram_o == $past(hwdata_i[15], 2))
      else $error("dram select does not follow write");
   a_fields_follow: assert property (afc_wr |-> ##2
      {area6_muxed_o, overlap_mode_o, read_strobe_duty_o, byte_strobe_select_o}
      == $past(hwdata_i[14:11], 2)) else $error("function fields do not follow write");
   a_afc_zeros: assert property (ph_rd && ph_addr == 12'h000 |-> hrdata_o[10:0] == 11'h0)
      else $error("function register low bits not zero");
   a_rwc_ones: assert property (ph_rd && ph_addr == 12'h004 |-> hrdata_o[7:2] == 6'h3f
      && hrdata_o[0]) else $error("read wait reserved bits not one");
   a_sample_map: assert property (rwc_wr |-> ##2 wait_sample_enable_o == $past(hwdata_i[15:8], 2))
      else $error("wait sample enables do not follow write");
   a_pitch_forced: assert property (!area1_dram_o && !$past(area1_dram_o) |-> dram_write_pitch_o)
      else $error("write pitch not long outside dram");
   a_periph_three: assert property (periph_go |-> ##[1:8] (cycle_done_o && cycle_states_o == 8'h03))
      else $error("peripheral read not three states");
   a_onchip_one: assert property (rom_go |-> ##[1:4] (cycle_done_o && cycle_states_o == 8'h01))
      else $error("on-chip read not one state");
   a_done_pulse: assert property (cycle_done_o |=> !cycle_done_o)
      else $error("done longer than one cycle");
   a_resp_okay: assert property (hresp_o == 1'b0)
      else $error("error response given");
   a_busy_follows: assert property (access_start_i && !cycle_busy_o |=> cycle_busy_o)
      else $error("timer not busy after start");
endmodule // bus_area_monitor

bind external_bus_area_wait_config bus_area_monitor bus_area_monitor_i (
   .clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .access_start_i(access_start_i), .access_area_i(access_area_i),
   .access_onchip_i(access_onchip_i), .cycle_done_o(cycle_done_o),
   .cycle_busy_o(cycle_busy_o), .hresp_o(hresp_o),
   .cycle_states_o(cycle_states_o), .area1_dram_o(area1_dram_o),
   .area6_muxed_o(area6_muxed_o), .overlap_mode_o(overlap_mode_o),
   .read_strobe_duty_o(read_strobe_duty_o), .byte_strobe_select_o(byte_strobe_select_o),
   .wait_sample_enable_o(wait_sample_enable_o), .dram_write_pitch_o(dram_write_pitch_o));

// ### tb/external_bus_area_wait_config_tb.sv
// self-checking bench for the area configuration block
`timescale 1ns/1ps
`include "bus_area_map.vh"
module external_bus_area_wait_config_tb;
   // ======================================
   // signals
   reg         clock_i  = 1'b0;
   reg         rstn_i   = 1'b0;
   reg         hsel_i   = 1'b0;
   reg  [11:0] haddr_i  = 12'h000;
   reg  [1:0]  htrans_i = 2'h0;
   reg         hwrite_i = 1'b0;
   reg  [31:0] hwdata_i = 32'h0;
   reg         go       = 1'b0;
   reg  [2:0]  area     = 3'h0;
   reg         wr_acc   = 1'b0;
   reg         onchip   = 1'b0;
   reg  [3:0]  stall    = 4'h0;
   reg         rf_mode  = 1'b0;
   reg         rfs      = 1'b0;
   reg  [1:0]  rfw      = 2'h2;
   reg  [31:0] q;
   reg  [15:0] pat [0:3];
   wire [31:0] hrdata;
   wire        hready;
   wire        wait_n;
   wire [4:0]  cfg;
   wire [7:0]  wse;
   wire        pitch;
   wire        done;
   wire [7:0]  states;
   integer     err_count   = 0;
   integer     checks_done = 0;
   integer     i;
   always #5 clock_i = ~clock_i;
   external_bus_area_wait_config external_bus_area_wait_config_i (
      .clock_i(clock_i), .rstn_i(rstn_i), .clken_i(1'b1), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(), .access_start_i(go), .access_area_i(area), .access_write_i(wr_acc),
      .access_onchip_i(onchip), .refresh_start_i(rfs), .refresh_wait_i(rfw),
      .wait_n_i(wait_n), .area1_dram_o(cfg[4]), .area6_muxed_o(cfg[3]),
      .overlap_mode_o(cfg[2]), .read_strobe_duty_o(cfg[1]), .byte_strobe_select_o(cfg[0]),
      .wait_sample_enable_o(wse), .dram_write_pitch_o(pitch), .cycle_busy_o(),
      .cycle_done_o(done), .cycle_states_o(states));
   wait_responder wait_responder_i (.clock_i(clock_i), .rstn_i(rstn_i), .start_i(go | rfs),
      .stall_i(stall), .wait_n_o(wait_n));
   // ======================================
   // tasks
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [8*8:1] nm, input [31:0] exp, input [31:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // bounded wait for a ready edge; a hang ends the run
   task ready_edge;
      integer n;
      begin
         n = 0;
         @(posedge clock_i);
         while (hready !== 1'b1 && n < 50) begin
            @(posedge clock_i);
            n = n + 1;
         end
         if (hready !== 1'b1) begin
            err_count = err_count + 1;
            complete_run;
         end
      end
   endtask
   task bus(input w, input [11:0] a, input [31:0] d);
      begin
         hsel_i <= 1'b1;
         htrans_i <= 2'h2;
         haddr_i <= a;
         hwrite_i <= w;
         ready_edge;
         hsel_i <= 1'b0;
         htrans_i <= 2'h0;
         hwdata_i <= d;
         ready_edge;
         q = hrdata;
      end
   endtask
   task rd(input [11:0] a, input [31:0] exp, input [8*8:1] nm);
      begin
         bus(1'b0, a, 32'h0);
         chk(nm, exp, q);
      end
   endtask
   // exp is the base count plus the wait lows still seen from the last fixed state on
   task cyc(input [2:0] ar, input oc, input w, input [3:0] st, input [7:0] exp);
      integer n;
      begin
         go <= !rf_mode;
         rfs <= rf_mode;
         area <= ar;
         onchip <= oc;
         wr_acc <= w;
         stall <= st;
         @(posedge clock_i);
         go <= 1'b0;
         rfs <= 1'b0;
         n = 0;
         while (done !== 1'b1 && n < 40) begin
            @(posedge clock_i);
            n = n + 1;
         end
         if (done !== 1'b1) begin
            err_count = err_count + 1;
            complete_run;
         end
         chk("states", {24'h0, exp}, {24'h0, states});
      end
   endtask
   // ======================================
   // sequence of tests
   initial begin
      pat[0] = 16'hf800;
      pat[1] = 16'h0000;
      pat[2] = 16'h5000;
      pat[3] = 16'ha800;
      repeat (20) @(posedge clock_i);
      rstn_i <= 1'b1;
      chk("cfg", 32'h0, {27'h0, cfg});
      chk("wse", 32'hff, {24'h0, wse});
      chk("pitch", 32'h1, {31'h0, pitch});
      rd(`AREA_FUNCTION_CONTROL_ADDR, 32'h0, "afc");
      rd(`READ_WAIT_CONTROL_ADDR, 32'hffff, "rwc");
      rd(12'h00c, 32'h0, "unmapped");
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, `AREA_FUNCTION_CONTROL_ADDR, {16'h0, pat[i]});
         rd(`AREA_FUNCTION_CONTROL_ADDR, {16'h0, pat[i]}, "afc");
         chk("cfg", {27'h0, pat[i][15:11]}, {27'h0, cfg});
      end
      // reserved bits written as software must, area 1 now dram
      bus(1'b1, `AREA_FUNCTION_CONTROL_ADDR, 32'h0000a000);
      rd(`AREA_FUNCTION_CONTROL_ADDR, 32'ha000, "afc");
      bus(1'b1, `READ_WAIT_CONTROL_ADDR, 32'h00fd);
      rd(`READ_WAIT_CONTROL_ADDR, 32'h00fd, "rwc");
      chk("wse", 32'h0, {24'h0, wse});
      chk("pitch", 32'h0, {31'h0, pitch});
      cyc(3'h3, 1'b0, 1'b0, 4'h0, 8'h01);
      cyc(3'h1, 1'b0, 1'b0, 4'h0, 8'h01);
      cyc(3'h1, 1'b0, 1'b1, 4'h0, 8'h01);
      cyc(3'h5, 1'b1, 1'b0, 4'h0, 8'h03);
      cyc(3'h0, 1'b1, 1'b0, 4'h0, 8'h01);
      cyc(3'h7, 1'b1, 1'b0, 4'h0, 8'h01);
      rf_mode = 1'b1;
      cyc(3'h1, 1'b0, 1'b0, 4'h6, 8'h01);
      rf_mode = 1'b0;
      bus(1'b1, `READ_WAIT_CONTROL_ADDR, 32'h5aff);
      rd(`READ_WAIT_CONTROL_ADDR, 32'h5aff, "rwc");
      chk("wse", 32'h5a, {24'h0, wse});
      bus(1'b1, `READ_WAIT_CONTROL_ADDR, 32'hffff);
      bus(1'b1, `AREA_FUNCTION_CONTROL_ADDR, 32'hf800);
      cyc(3'h3, 1'b0, 1'b0, 4'h0, 8'h02);
      cyc(3'h6, 1'b0, 1'b0, 4'h0, 8'h04);
      cyc(3'h5, 1'b1, 1'b0, 4'h0, 8'h03);
      cyc(3'h1, 1'b0, 1'b0, 4'h0, 8'h02);
      cyc(3'h1, 1'b0, 1'b1, 4'h0, 8'h02);
      cyc(3'h3, 1'b0, 1'b0, 4'h3, 8'h04);
      cyc(3'h6, 1'b0, 1'b0, 4'h6, 8'h07);
      cyc(3'h2, 1'b0, 1'b0, 4'h0, 8'h05);
      cyc(3'h0, 1'b0, 1'b0, 4'h6, 8'h07);
      rfw <= 2'h3;
      rf_mode = 1'b1;
      cyc(3'h1, 1'b0, 1'b0, 4'h6, 8'h04);
      rf_mode = 1'b0;
      bus(1'b1, `LONG_WAIT_CONTROL_ADDR, 32'h0);
      rd(`LONG_WAIT_CONTROL_ADDR, 32'h0, "lwc");
      cyc(3'h2, 1'b0, 1'b0, 4'h0, 8'h02);
      complete_run;
   end
endmodule // external_bus_area_wait_config_tb
